// file: hdl/ppc_pkg.sv
// Constants and carrier types for the port 1 / port 2 pin configuration block.
// Assumes an 8-bit paged special function register bus driven by the core.
package ppc_pkg;
	// ==========================================================
	// Widths
	localparam int PORT_WIDTH = 8;
	localparam int PAGE_WIDTH = 8;

	// ==========================================================
	// Register pages
	localparam logic [7:0] PAGE_BASE = 8'h00;
	localparam logic [7:0] PAGE_ALT = 8'h0F;

	// ==========================================================
	// Register addresses
	localparam logic [7:0] ADDR_PORT2_PIN_DATA = 8'hA0;
	localparam logic [7:0] ADDR_PORT1_DRIVE_CFG = 8'hA5;
	localparam logic [7:0] ADDR_PORT1_BYPASS = 8'hD5;
	localparam logic [7:0] ADDR_PORT2_BYPASS = 8'hD6;
	localparam logic [7:0] ADDR_PORT1_ANALOG = 8'hF2;
	localparam logic [7:0] ADDR_PORT2_ANALOG = 8'hF3;

	// ==========================================================
	// Field positions
	localparam int PORT2_ANALOG_RSVD_BIT = 7;
	localparam int PORT2_ANALOG_MSB = 6;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_PORT2_PIN_DATA = 8'hFF;
	localparam logic [7:0] RST_PORT1_OUTPUT_TYPE = 8'h00;
	localparam logic [7:0] RST_PORT1_DRIVE_LEVEL = 8'h00;
	localparam logic [7:0] RST_PORT1_BYPASS = 8'h00;
	localparam logic [7:0] RST_PORT2_BYPASS = 8'h00;
	localparam logic [7:0] RST_PORT1_ANALOG = 8'hFF;
	localparam logic [7:0] RST_PORT2_ANALOG = 8'hFF;
	localparam logic RSVD_READ_VALUE = 1'b1;

	// ==========================================================
	// Per-pin control carried to pad cells and crossbar decoder
	typedef struct packed {
		logic [7:0] bypass;
		logic [7:0] rx_en;
		logic [7:0] pullup_en;
	} ppc_port_ctrl_s;

	// Port 1 driver configuration
	typedef struct packed {
		logic [7:0] push_pull;
		logic [7:0] high_drive;
	} ppc_drive_s;

	// Register selected by the current bus address and page
	typedef enum {
		SEL_NONE,
		SEL_PORT2_DATA,
		SEL_PORT1_OUT_TYPE,
		SEL_PORT1_DRIVE,
		SEL_PORT1_BYPASS,
		SEL_PORT2_BYPASS,
		SEL_PORT1_ANALOG,
		SEL_PORT2_ANALOG
	} ppc_sel_e;
endpackage : ppc_pkg

// file: hdl/ppc_pin_sync.sv
// Two-flop synchroniser for a vector of pad input levels.
// Assumes each bit is an independent asynchronous level.
`timescale 1ns/10ps
module ppc_pin_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// ==========================================================
	// Synchroniser stages
	logic [WIDTH-1:0] stage1;

	// One pair of flops per pin; the first stage feeds only the second
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				stage1[i] <= 1'b0;
				sync_out[i] <= 1'b0;
			end else begin
				stage1[i] <= async_in[i];
				sync_out[i] <= stage1[i];
			end
		end
	end
endmodule : ppc_pin_sync

// file: hdl/ppc_pin_config.sv
// Port 1 / port 2 pin configuration registers and pad control vectors.
// Assumes the core drives a paged register bus synchronous to clk and the
// pad pins arrive asynchronously.
`timescale 1ns/10ps
module ppc_pin_config #(
	parameter int WIDTH = ppc_pkg::PORT_WIDTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register bus
	input wire logic [7:0] bus_addr,
	input wire logic [ppc_pkg::PAGE_WIDTH-1:0] bus_page,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_bit_wr,
	input wire logic [2:0] bus_bit_sel,
	input wire logic bus_bit_val,
	output logic [7:0] bus_rdata,
	output logic bus_rd_hit,
	// Pad pins
	input wire logic [WIDTH-1:0] port2_pad_in,
	output logic [WIDTH-1:0] port2_latch,
	// Pad and crossbar control
	output ppc_pkg::ppc_port_ctrl_s port1_ctrl,
	output ppc_pkg::ppc_port_ctrl_s port2_ctrl,
	output ppc_pkg::ppc_drive_s port1_drive
);
	// ==========================================================
	// Storage
	logic [7:0] port1_output_type;
	logic [7:0] port1_drive_level;
	logic [7:0] port1_crossbar_bypass;
	logic [7:0] port2_crossbar_bypass;
	logic [7:0] port1_analog_select;
	logic [ppc_pkg::PORT2_ANALOG_MSB:0] port2_analog_select;
	logic [7:0] port2_pin_data;
	logic [WIDTH-1:0] port2_pin_sync;
	logic [7:0] port2_analog_view;
	logic [7:0] port2_readback;
	ppc_pkg::ppc_sel_e sel;
	logic [7:0] next_rdata;
	logic wr_port2_data;
	logic page_base;
	logic page_alt;

	// ==========================================================
	// Pin synchroniser
	ppc_pin_sync #(
		.WIDTH(WIDTH)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(port2_pad_in),
		.sync_out(port2_pin_sync)
	);

	// ==========================================================
	// Address decode
	assign page_base = (bus_page == ppc_pkg::PAGE_BASE);
	assign page_alt = (bus_page == ppc_pkg::PAGE_ALT);

	// Select one register from address and page
	always_comb begin
		sel = ppc_pkg::SEL_NONE;
		case (bus_addr)
			ppc_pkg::ADDR_PORT2_PIN_DATA: begin
				sel = ppc_pkg::SEL_PORT2_DATA;
			end
			ppc_pkg::ADDR_PORT1_DRIVE_CFG: begin
				if (page_base) begin
					sel = ppc_pkg::SEL_PORT1_OUT_TYPE;
				end else if (page_alt) begin
					sel = ppc_pkg::SEL_PORT1_DRIVE;
				end
			end
			ppc_pkg::ADDR_PORT1_BYPASS: begin
				if (page_base) begin
					sel = ppc_pkg::SEL_PORT1_BYPASS;
				end
			end
			ppc_pkg::ADDR_PORT2_BYPASS: begin
				if (page_base) begin
					sel = ppc_pkg::SEL_PORT2_BYPASS;
				end
			end
			ppc_pkg::ADDR_PORT1_ANALOG: begin
				if (page_base) begin
					sel = ppc_pkg::SEL_PORT1_ANALOG;
				end
			end
			ppc_pkg::ADDR_PORT2_ANALOG: begin
				if (page_base) begin
					sel = ppc_pkg::SEL_PORT2_ANALOG;
				end
			end
			default: begin
				sel = ppc_pkg::SEL_NONE;
			end
		endcase
	end

	assign wr_port2_data = bus_wr && (sel == ppc_pkg::SEL_PORT2_DATA);

	// ==========================================================
	// Crossbar bypass masks
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port1_crossbar_bypass <= ppc_pkg::RST_PORT1_BYPASS;
		end else if (bus_wr && sel == ppc_pkg::SEL_PORT1_BYPASS) begin
			port1_crossbar_bypass <= bus_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port2_crossbar_bypass <= ppc_pkg::RST_PORT2_BYPASS;
		end else if (bus_wr && sel == ppc_pkg::SEL_PORT2_BYPASS) begin
			port2_crossbar_bypass <= bus_wdata;
		end
	end

	// ==========================================================
	// Analog selects; port 2 bit 7 is not stored
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port1_analog_select <= ppc_pkg::RST_PORT1_ANALOG;
		end else if (bus_wr && sel == ppc_pkg::SEL_PORT1_ANALOG) begin
			port1_analog_select <= bus_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port2_analog_select <= ppc_pkg::RST_PORT2_ANALOG[ppc_pkg::PORT2_ANALOG_MSB:0];
		end else if (bus_wr && sel == ppc_pkg::SEL_PORT2_ANALOG) begin
			port2_analog_select <= bus_wdata[ppc_pkg::PORT2_ANALOG_MSB:0];
		end
	end

	// Reserved bit always reads as one and keeps pin 7 digital
	assign port2_analog_view = {ppc_pkg::RSVD_READ_VALUE, port2_analog_select};

	// ==========================================================
	// Port 1 driver configuration, shared address split by page
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port1_output_type <= ppc_pkg::RST_PORT1_OUTPUT_TYPE;
		end else if (bus_wr && sel == ppc_pkg::SEL_PORT1_OUT_TYPE) begin
			port1_output_type <= bus_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port1_drive_level <= ppc_pkg::RST_PORT1_DRIVE_LEVEL;
		end else if (bus_wr && sel == ppc_pkg::SEL_PORT1_DRIVE) begin
			port1_drive_level <= bus_wdata;
		end
	end

	// ==========================================================
	// Port 2 output latch: byte write wins over a bit write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port2_pin_data <= ppc_pkg::RST_PORT2_PIN_DATA;
		end else if (wr_port2_data) begin
			port2_pin_data <= bus_wdata;
		end else if (bus_bit_wr && bus_addr == ppc_pkg::ADDR_PORT2_PIN_DATA) begin
			port2_pin_data[bus_bit_sel] <= bus_bit_val;
		end
	end

	// ==========================================================
	// Pin readback; analog pins have no receiver so read low
	assign port2_readback = port2_pin_sync & port2_analog_view;

	// Read multiplexer
	always_comb begin
		next_rdata = 8'h00;
		case (sel)
			ppc_pkg::SEL_PORT2_DATA: next_rdata = port2_readback;
			ppc_pkg::SEL_PORT1_OUT_TYPE: next_rdata = port1_output_type;
			ppc_pkg::SEL_PORT1_DRIVE: next_rdata = port1_drive_level;
			ppc_pkg::SEL_PORT1_BYPASS: next_rdata = port1_crossbar_bypass;
			ppc_pkg::SEL_PORT2_BYPASS: next_rdata = port2_crossbar_bypass;
			ppc_pkg::SEL_PORT1_ANALOG: next_rdata = port1_analog_select;
			ppc_pkg::SEL_PORT2_ANALOG: next_rdata = port2_analog_view;
			default: next_rdata = 8'h00;
		endcase
	end

	// Registered read answer, one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata <= 8'h00;
			bus_rd_hit <= 1'b0;
		end else begin
			bus_rd_hit <= bus_rd && (sel != ppc_pkg::SEL_NONE);
			if (bus_rd) begin
				bus_rdata <= next_rdata;
			end
		end
	end

	// ==========================================================
	// Continuous control vectors to pads and crossbar
	assign port1_ctrl.bypass = port1_crossbar_bypass;
	assign port1_ctrl.rx_en = port1_analog_select;
	assign port1_ctrl.pullup_en = port1_analog_select;
	assign port2_ctrl.bypass = port2_crossbar_bypass;
	assign port2_ctrl.rx_en = port2_analog_view;
	assign port2_ctrl.pullup_en = port2_analog_view;
	// Driver fields never look at the analog select
	assign port1_drive.push_pull = port1_output_type;
	assign port1_drive.high_drive = port1_drive_level;
	assign port2_latch = port2_pin_data;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_bypass_write: assert property (
		bus_wr && page_base && bus_addr == ppc_pkg::ADDR_PORT1_BYPASS
		|=> port1_ctrl.bypass == $past(bus_wdata))
		else $error("port 1 bypass mask did not take written value");

	a_bypass_page: assert property (
		bus_wr && !page_base && bus_addr == ppc_pkg::ADDR_PORT1_BYPASS
		|=> $stable(port1_ctrl.bypass))
		else $error("port 1 bypass mask written from wrong page");

	a_bypass2_write: assert property (
		bus_wr && page_base && bus_addr == ppc_pkg::ADDR_PORT2_BYPASS
		|=> port2_ctrl.bypass == $past(bus_wdata) && $stable(port1_ctrl.bypass))
		else $error("port 2 bypass mask write wrong");

	a_analog_gates: assert property (
		bus_wr && page_base && bus_addr == ppc_pkg::ADDR_PORT1_ANALOG
		|=> port1_ctrl.rx_en == $past(bus_wdata)
		&& port1_ctrl.pullup_en == $past(bus_wdata))
		else $error("receiver or pull-up not following analog select");

	a_port2_analog: assert property (
		bus_wr && page_base && bus_addr == ppc_pkg::ADDR_PORT2_ANALOG
		|=> port2_ctrl.pullup_en == {ppc_pkg::RSVD_READ_VALUE, $past(bus_wdata[6:0])})
		else $error("port 2 analog select write wrong");

	a_driver_kept: assert property (
		bus_wr && bus_addr == ppc_pkg::ADDR_PORT1_ANALOG
		|=> $stable(port1_drive.push_pull) && $stable(port1_drive.high_drive))
		else $error("analog select write disturbed driver setup");

	a_reserved_one: assert property (
		bus_rd && page_base && bus_addr == ppc_pkg::ADDR_PORT2_ANALOG
		|=> bus_rdata[ppc_pkg::PORT2_ANALOG_RSVD_BIT] && port2_ctrl.rx_en[7])
		else $error("reserved analog select bit not one");

	a_page_split: assert property (
		bus_wr && page_alt && bus_addr == ppc_pkg::ADDR_PORT1_DRIVE_CFG
		|=> port1_drive.high_drive == $past(bus_wdata)
		&& $stable(port1_drive.push_pull))
		else $error("drive level write reached the wrong register");

	a_drive_split: assert property (
		bus_wr && page_base && bus_addr == ppc_pkg::ADDR_PORT1_DRIVE_CFG
		|=> $stable(port1_drive.high_drive))
		else $error("output type write reached drive level");

	a_type_write: assert property (
		bus_wr && page_base && bus_addr == ppc_pkg::ADDR_PORT1_DRIVE_CFG
		|=> port1_drive.push_pull == $past(bus_wdata))
		else $error("output type did not take written value");

	a_latch_write: assert property (
		bus_wr && bus_addr == ppc_pkg::ADDR_PORT2_PIN_DATA
		|=> port2_latch == $past(bus_wdata))
		else $error("port 2 latch did not take written value");

	a_bit_write: assert property (
		bus_bit_wr && !bus_wr && bus_addr == ppc_pkg::ADDR_PORT2_PIN_DATA
		|=> port2_latch[$past(bus_bit_sel)] == $past(bus_bit_val))
		else $error("port 2 single bit write lost");

	a_pin_read: assert property (
		bus_rd && bus_addr == ppc_pkg::ADDR_PORT2_PIN_DATA
		|=> bus_rd_hit && bus_rdata == $past(port2_readback))
		else $error("port 2 read did not return pin levels");

	a_analog_read_zero: assert property (
		bus_rd && bus_addr == ppc_pkg::ADDR_PORT2_PIN_DATA
		|=> (bus_rdata & ~port2_ctrl.rx_en) == 8'h00)
		else $error("analog pin read back as high");

	a_readback_cfg: assert property (
		bus_wr && page_base && bus_addr == ppc_pkg::ADDR_PORT1_ANALOG ##1
		bus_rd && page_base && bus_addr == ppc_pkg::ADDR_PORT1_ANALOG && !bus_wr
		|=> bus_rdata == $past(bus_wdata, 2))
		else $error("configuration readback mismatch");

	a_unmapped_zero: assert property (
		bus_rd && sel == ppc_pkg::SEL_NONE |=> bus_rdata == 8'h00 && !bus_rd_hit)
		else $error("unmapped read returned data");

	a_hit_pulse: assert property (
		bus_rd_hit |-> $past(bus_rd) && $past(sel) != ppc_pkg::SEL_NONE)
		else $error("read hit without a mapped read");

	a_rdata_hold: assert property (
		!bus_rd |=> $stable(bus_rdata))
		else $error("read data changed without a read");

	// Main scenarios
	c_analog_pin: cover property (bus_wr && sel == ppc_pkg::SEL_PORT1_ANALOG
		&& bus_wdata != 8'hFF);
	c_drive_page: cover property (bus_wr && sel == ppc_pkg::SEL_PORT1_DRIVE);
	c_pin_read: cover property (bus_rd && sel == ppc_pkg::SEL_PORT2_DATA
		##1 bus_rdata != port2_latch);
	c_bit_write: cover property (bus_bit_wr && !bus_wr
		&& bus_addr == ppc_pkg::ADDR_PORT2_PIN_DATA);
	c_write_read: cover property (bus_wr ##1 bus_rd && sel == ppc_pkg::SEL_PORT1_ANALOG);
endmodule : ppc_pin_config

// file: bench/ppc_pad_model.sv
// Behavioural model of the port 2 pad cells seen from the configuration block.
// Assumes open-drain pads: a pin is pulled low by its latch or by the outside world.
`timescale 1ns/10ps
module ppc_pad_model (
	// Clock
	input wire logic clk,
	// Block side
	input wire logic [7:0] port2_latch,
	input wire logic [7:0] pullup_en,
	// Outside world
	input wire logic [7:0] ext_low,
	output logic [7:0] pad_level
);
	// ==========================================================
	// Pad levels
	logic [7:0] float_pat;

	// Undriven pins wander, so the pattern flips every cycle
	initial float_pat = 8'h55;
	always @(posedge clk) begin
		float_pat <= ~float_pat;
	end

	// Latch low or outside pull-down wins; otherwise an enabled weak pull-up drives high, else the pin floats
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (ext_low[i] || !port2_latch[i])
				pad_level[i] = 1'b0;
			else if (pullup_en[i])
				pad_level[i] = 1'b1;
			else
				pad_level[i] = float_pat[i];
		end
	end
endmodule : ppc_pad_model

// file: bench/ppc_pin_config_bench.sv
// Self-checking bench for the port 1 / port 2 pin configuration block.
// Assumes ppc_pkg, the design and the pad model are compiled first.
`timescale 1ns/10ps
module ppc_pin_config_bench;
	// ==========================================================
	// Signals
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] bus_addr = 8'h00;
	logic [7:0] bus_page = 8'h00;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [7:0] bus_wdata = 8'h00;
	logic bus_bit_wr = 1'b0;
	logic [2:0] bus_bit_sel = 3'h0;
	logic bus_bit_val = 1'b0;
	logic [7:0] bus_rdata;
	logic bus_rd_hit;
	logic [7:0] pad_level;
	logic [7:0] ext_low = 8'h00;
	logic [7:0] port2_latch;
	ppc_pkg::ppc_port_ctrl_s port1_ctrl;
	ppc_pkg::ppc_port_ctrl_s port2_ctrl;
	ppc_pkg::ppc_drive_s port1_drive;
	int failures = 0;
	int n_checks = 0;
	// Register table: address, page, reset value, written value, read back
	logic [7:0] t_addr [6] = '{8'hD5, 8'hD6, 8'hF2, 8'hF3, 8'hA5, 8'hA5};
	logic [7:0] t_page [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F};
	logic [7:0] t_rst [6] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
	logic [7:0] t_val [6] = '{8'hA5, 8'h3C, 8'h0F, 8'h70, 8'h96, 8'h69};
	logic [7:0] t_back [6] = '{8'hA5, 8'h3C, 8'h0F, 8'hF0, 8'h96, 8'h69};

	// Clock of 40 ns
	always #20 clk = ~clk;

	// ==========================================================
	// Design and pad model
	ppc_pin_config dut (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_page(bus_page),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_bit_wr(bus_bit_wr),
		.bus_bit_sel(bus_bit_sel), .bus_bit_val(bus_bit_val), .bus_rdata(bus_rdata),
		.bus_rd_hit(bus_rd_hit), .port2_pad_in(pad_level), .port2_latch(port2_latch),
		.port1_ctrl(port1_ctrl), .port2_ctrl(port2_ctrl), .port1_drive(port1_drive));
	ppc_pad_model pads (.clk(clk), .port2_latch(port2_latch),
		.pullup_en(port2_ctrl.pullup_en), .ext_low(ext_low), .pad_level(pad_level));

	// ==========================================================
	// Tasks
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk8

	task automatic wr(input logic [7:0] addr, input logic [7:0] page, input logic [7:0] data);
		@(posedge clk);
		bus_addr <= addr;
		bus_page <= page;
		bus_wdata <= data;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
		#1;
	endtask : wr

	// Write, then read the same register on the very next cycle
	task automatic wr_rd(input logic [7:0] addr, input logic [7:0] page, input logic [7:0] data);
		@(posedge clk);
		bus_addr <= addr;
		bus_page <= page;
		bus_wdata <= data;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1;
		chk8("write then read", data, bus_rdata);
	endtask : wr_rd

	task automatic bw(input logic [7:0] page, input logic [2:0] sel, input logic val);
		@(posedge clk);
		bus_addr <= 8'hA0;
		bus_page <= page;
		bus_bit_sel <= sel;
		bus_bit_val <= val;
		bus_bit_wr <= 1'b1;
		@(posedge clk);
		bus_bit_wr <= 1'b0;
		#1;
	endtask : bw

	task automatic rd(input logic [7:0] addr, input logic [7:0] page, input logic [7:0] exp,
		input logic hit);
		@(posedge clk);
		bus_addr <= addr;
		bus_page <= page;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1;
		chk8("read data", exp, bus_rdata);
		chk8("read hit", {7'h00, hit}, {7'h00, bus_rd_hit});
	endtask : rd

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	// ==========================================================
	// Watchdog: the tests need under a hundred cycles
	initial begin
		repeat (3000) @(posedge clk);
		failures++;
		report_and_stop();
	end

	// ==========================================================
	// Test sequence
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) rd(t_addr[i], t_page[i], t_rst[i], 1'b1);
		rd(8'hA0, 8'h00, 8'hFF, 1'b1);
		chk8("latch", 8'hFF, port2_latch);
		// Every configuration register, reserved bit written 0 once
		for (int i = 0; i < 6; i++) wr(t_addr[i], t_page[i], t_val[i]);
		for (int i = 0; i < 6; i++) rd(t_addr[i], t_page[i], t_back[i], 1'b1);
		chk8("port1 bypass", 8'hA5, port1_ctrl.bypass);
		chk8("port2 bypass", 8'h3C, port2_ctrl.bypass);
		chk8("port1 rx", 8'h0F, port1_ctrl.rx_en);
		chk8("port1 pullup", 8'h0F, port1_ctrl.pullup_en);
		chk8("port2 rx", 8'hF0, port2_ctrl.rx_en);
		chk8("port2 pullup", 8'hF0, port2_ctrl.pullup_en);
		chk8("push pull", 8'h96, port1_drive.push_pull);
		chk8("high drive", 8'h69, port1_drive.high_drive);
		// Wrong page and unmapped address are ignored
		wr(8'hD5, 8'h0F, 8'hFF);
		rd(8'hD5, 8'h0F, 8'h00, 1'b0);
		rd(8'hD5, 8'h00, 8'hA5, 1'b1);
		rd(8'h11, 8'h00, 8'h00, 1'b0);
		chk8("push pull", 8'h96, port1_drive.push_pull);
		// Port 2 latch by byte and by bit, pins read back
		wr(8'hD6, 8'h00, 8'hFF);
		wr(8'hF3, 8'h00, 8'hFC);
		wr(8'hA0, 8'h0F, 8'hF0);
		bw(8'h00, 3'h1, 1'b1);
		bw(8'h0F, 3'h6, 1'b0);
		chk8("latch", 8'hB2, port2_latch);
		ext_low <= 8'h10;
		repeat (4) @(posedge clk);
		rd(8'hA0, 8'h0F, 8'hA0, 1'b1);
		// Back to back write and read of one register
		wr_rd(8'hF2, 8'h00, 8'h3C);
		chk8("port1 rx", 8'h3C, port1_ctrl.rx_en);
		// Second reset in mid-run
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk8("port1 bypass", 8'h00, port1_ctrl.bypass);
		chk8("latch", 8'hFF, port2_latch);
		chk8("port2 rx", 8'hFF, port2_ctrl.rx_en);
		// Bus answers again straight after the release; pins need two edges
		rd(8'hA5, 8'h0F, 8'h00, 1'b1);
		rd(8'hF3, 8'h00, 8'hFF, 1'b1);
		rd(8'hA0, 8'h00, 8'hEF, 1'b1);
		report_and_stop();
	end
endmodule : ppc_pin_config_bench
